// [fsab_bank.sv]
/*
 * Fault status bank: seven sticky status registers, their force mirrors
 * and six alert gates (misc has none), plus the open-drain alert pin logic.
 * Assumes the serial-port engine presents one decoded command access per
 * cycle on i_req and takes o_rd_data when o_rd_valid pulses.
 */
`timescale 1ns/10ps
module fsab_bank (
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_sys_rst,
    input  wire fsab_pkg::fsab_req_type  i_req,
    input  wire fsab_pkg::fsab_event_type i_ev,
    input  wire logic                    i_fault_timer_pin,
    input  wire logic                    i_overvolt_pin,
    input  wire logic                    i_undervolt_pin,
    input  wire logic                    i_enable_pin,
    input  wire logic                    i_alert_in,
    output logic [7:0]                   o_rd_data,
    output logic                         o_rd_valid,
    output logic                         o_alert_out,
    output logic                         o_alert_oe
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [fsab_pkg::FSAB_NPIN-1:0] pin_raw;
    logic [fsab_pkg::FSAB_NPIN-1:0] sync1_reg;
    logic [fsab_pkg::FSAB_NPIN-1:0] sync2_reg;
    logic                           en_prev_reg;
    logic [1:0]                     settle_reg;
    logic                           settled;

    assign pin_raw = {i_alert_in, i_enable_pin, i_undervolt_pin,
                      i_overvolt_pin, i_fault_timer_pin};

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sync1_reg <= fsab_pkg::FSAB_SYNC_RST;
            sync2_reg <= fsab_pkg::FSAB_SYNC_RST;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    // the synchroniser shows reset zeros first; a change then is not real
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            settle_reg  <= 2'h0;
            en_prev_reg <= 1'b0;
        end else begin
            en_prev_reg <= sync2_reg[fsab_pkg::FSAB_PIN_EN];
            if (!settled) begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    assign settled = (settle_reg == fsab_pkg::FSAB_SETTLE_CYCLES);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    fsab_pkg::fsab_acc_type acc_kind;
    logic [2:0]             acc_idx;
    logic                   acc_any;
    logic                   acc_unmapped;

    always_comb begin
        acc_kind = fsab_pkg::FSAB_ACC_NONE;
        acc_idx  = 3'h0;
        for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
            if (i_req.cmd == fsab_pkg::FSAB_STATUS_OFS[i]) begin
                acc_kind = fsab_pkg::FSAB_ACC_STATUS;
                acc_idx  = 3'(i);
            end else if (i_req.cmd == fsab_pkg::FSAB_FORCE_OFS[i]) begin
                acc_kind = fsab_pkg::FSAB_ACC_FORCE;
                acc_idx  = 3'(i);
            end else if (fsab_pkg::FSAB_GATE_PRESENT[i] &&
                         i_req.cmd == fsab_pkg::FSAB_GATE_OFS[i]) begin
                acc_kind = fsab_pkg::FSAB_ACC_GATE;
                acc_idx  = 3'(i);
            end
        end
    end

    assign acc_any      = i_req.wr | i_req.rd;
    assign acc_unmapped = acc_any && (acc_kind == fsab_pkg::FSAB_ACC_NONE);

    // ------------------------------------------------------------
    // event collection
    // ------------------------------------------------------------
    logic [7:0] ev_vec [fsab_pkg::FSAB_NREG];
    logic       first_alert_ev;
    logic       en_change_ev;

    assign en_change_ev = settled && (sync2_reg[fsab_pkg::FSAB_PIN_EN] != en_prev_reg);

    always_comb begin
        for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
            ev_vec[i] = 8'h00;
        end
        ev_vec[fsab_pkg::FSAB_VOUT_IDX][fsab_pkg::FSAB_OUT_OVW_BIT] =
            i_ev.out_overvolt_warn;
        ev_vec[fsab_pkg::FSAB_VOUT_IDX][fsab_pkg::FSAB_OUT_UVW_BIT] =
            i_ev.out_undervolt_warn;
        ev_vec[fsab_pkg::FSAB_IOUT_IDX][fsab_pkg::FSAB_OC_TRIP_BIT] =
            i_ev.overcurrent_active & sync2_reg[fsab_pkg::FSAB_PIN_TIMER];
        ev_vec[fsab_pkg::FSAB_IOUT_IDX][fsab_pkg::FSAB_OC_WARN_BIT] =
            i_ev.overcurrent_warn;
        ev_vec[fsab_pkg::FSAB_INPUT_IDX][fsab_pkg::FSAB_IN_OVT_BIT] =
            sync2_reg[fsab_pkg::FSAB_PIN_OV];
        ev_vec[fsab_pkg::FSAB_INPUT_IDX][fsab_pkg::FSAB_IN_OVW_BIT] =
            i_ev.in_overvolt_warn;
        ev_vec[fsab_pkg::FSAB_INPUT_IDX][fsab_pkg::FSAB_IN_UVW_BIT] =
            i_ev.in_undervolt_warn;
        ev_vec[fsab_pkg::FSAB_INPUT_IDX][fsab_pkg::FSAB_IN_UVT_BIT] =
            sync2_reg[fsab_pkg::FSAB_PIN_UV];
        ev_vec[fsab_pkg::FSAB_INPUT_IDX][fsab_pkg::FSAB_PWR_WARN_BIT] =
            i_ev.input_power_warn;
        ev_vec[fsab_pkg::FSAB_TEMP_IDX][fsab_pkg::FSAB_OT_TRIP_BIT] =
            i_ev.overheat_trip;
        ev_vec[fsab_pkg::FSAB_TEMP_IDX][fsab_pkg::FSAB_OT_WARN_BIT] =
            i_ev.overheat_warn;
        ev_vec[fsab_pkg::FSAB_TEMP_IDX][fsab_pkg::FSAB_UT_WARN_BIT] =
            i_ev.undercool_warn;
        // an access to an unknown command code counts as a bad command
        ev_vec[fsab_pkg::FSAB_CML_IDX][fsab_pkg::FSAB_BAD_CMD_BIT] =
            i_ev.bad_cmd | acc_unmapped;
        ev_vec[fsab_pkg::FSAB_CML_IDX][fsab_pkg::FSAB_BAD_DATA_BIT] =
            i_ev.bad_data;
        ev_vec[fsab_pkg::FSAB_CML_IDX][fsab_pkg::FSAB_PKT_ERR_BIT] =
            i_ev.packet_check_error;
        ev_vec[fsab_pkg::FSAB_CML_IDX][fsab_pkg::FSAB_MISC_COMM_BIT] =
            i_ev.misc_comm_fault;
        ev_vec[fsab_pkg::FSAB_OTHER_IDX][fsab_pkg::FSAB_FIRST_BIT] =
            first_alert_ev;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_EN_CHG_BIT] =
            en_change_ev;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_TSD_BIT] =
            i_ev.thermal_shutdown_trip;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_LOCKOUT_BIT] =
            i_ev.supply_lockout;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_INST_OP_BIT] =
            i_ev.instant_overpower_trip;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_TIMED_OP_BIT] =
            i_ev.timed_overpower_trip;
        ev_vec[fsab_pkg::FSAB_MFR_IDX][fsab_pkg::FSAB_FET_BAD_BIT] =
            i_ev.pass_transistor_bad;
    end

    // ------------------------------------------------------------
    // status, force and gate registers
    // ------------------------------------------------------------
    logic [7:0] status_reg [fsab_pkg::FSAB_NREG];
    logic [7:0] gate_reg   [fsab_pkg::FSAB_NREG];
    logic       wr_clr;
    logic       wr_frc;

    assign wr_clr = i_req.wr && (acc_kind == fsab_pkg::FSAB_ACC_STATUS);
    assign wr_frc = i_req.wr && (acc_kind == fsab_pkg::FSAB_ACC_FORCE);

    // set beats clear: an event in the clearing cycle survives
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
                status_reg[i] <= fsab_pkg::FSAB_STATUS_RST;
            end
        end else begin
            for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
                if (acc_idx == 3'(i)) begin
                    status_reg[i] <= ((status_reg[i] & ~(wr_clr ? i_req.wdata : 8'h00))
                                     | (wr_frc ? i_req.wdata : 8'h00) | ev_vec[i])
                                     & fsab_pkg::FSAB_IMPL[i];
                end else begin
                    status_reg[i] <= (status_reg[i] | ev_vec[i]) & fsab_pkg::FSAB_IMPL[i];
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
                gate_reg[i] <= fsab_pkg::FSAB_GATE_RST[i];
            end
        end else if (i_req.wr && acc_kind == fsab_pkg::FSAB_ACC_GATE) begin
            gate_reg[acc_idx] <= i_req.wdata & fsab_pkg::FSAB_IMPL[acc_idx];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rd_data  <= fsab_pkg::FSAB_RDATA_RST;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_req.rd;
            if (i_req.rd) begin
                if (acc_kind == fsab_pkg::FSAB_ACC_GATE) begin
                    o_rd_data <= gate_reg[acc_idx];
                end else if (acc_kind == fsab_pkg::FSAB_ACC_NONE) begin
                    o_rd_data <= fsab_pkg::FSAB_RDATA_RST;
                end else begin
                    o_rd_data <= status_reg[acc_idx];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // alert pin
    // ------------------------------------------------------------
    logic alert_next;

    // misc register stays off the pin, else its own bit would hold it low
    always_comb begin
        alert_next = 1'b0;
        for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
            if (fsab_pkg::FSAB_GATE_PRESENT[i]) begin
                alert_next = alert_next | (|(status_reg[i] & ~gate_reg[i]));
            end
        end
    end

    // first only if the shared line was still idle when we start pulling
    assign first_alert_ev = alert_next && !o_alert_oe &&
                            sync2_reg[fsab_pkg::FSAB_PIN_ALERT];

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_alert_oe  <= 1'b0;
            o_alert_out <= 1'b0;
        end else begin
            o_alert_oe  <= alert_next;
            o_alert_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic reserved_seen;

    always_comb begin
        reserved_seen = 1'b0;
        for (int i = 0; i < fsab_pkg::FSAB_NREG; i++) begin
            reserved_seen = reserved_seen | (|(status_reg[i] & ~fsab_pkg::FSAB_IMPL[i]))
                            | (|(gate_reg[i] & ~fsab_pkg::FSAB_IMPL[i]));
        end
    end

    chk_out_ovw_set:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_ev.out_overvolt_warn |=> status_reg[0][6])
    else $error("output overvoltage warning not latched");

    chk_out_uvw_set:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_ev.out_undervolt_warn |=> status_reg[0][5])
    else $error("output undervoltage warning not latched");

    chk_oc_trip_set:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_ev.overcurrent_active && sync2_reg[0]) |=> status_reg[1][7])
    else $error("overcurrent trip not latched");

    chk_oc_trip_cause:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(status_reg[1][7]) |-> $past(i_ev.overcurrent_active && sync2_reg[0])
            || $past(i_req.wr && acc_kind == fsab_pkg::FSAB_ACC_FORCE))
    else $error("overcurrent trip set without cause");

    chk_ov_pin_trip:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_overvolt_pin [*3] |=> status_reg[2][7])
    else $error("overvoltage pin not latched within three cycles");

    chk_uv_pin_trip:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_undervolt_pin [*3] |=> status_reg[2][4])
    else $error("undervoltage pin not latched within three cycles");

    chk_power_warn:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_ev.input_power_warn |=> status_reg[2][0])
    else $error("input power warning not latched");

    chk_temp_flags:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_ev.overheat_trip || i_ev.overheat_warn || i_ev.undercool_warn) |=>
        (status_reg[3] & 8'hE0) != 8'h00)
    else $error("temperature event not latched");

    chk_bad_cmd_unmapped:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        acc_unmapped |=> status_reg[4][7] && (!o_rd_valid || o_rd_data == 8'h00))
    else $error("unmapped command not flagged");

    chk_comms_flags:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_ev.bad_data || i_ev.packet_check_error || i_ev.misc_comm_fault) |=>
        (status_reg[4] & 8'h62) != 8'h00)
    else $error("communication event not latched");

    chk_first_alert:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        ($rose(o_alert_oe) && $past(sync2_reg[4])) |-> status_reg[5][0])
    else $error("first alert not recorded");

    chk_enable_change:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        en_change_ev |=> status_reg[6][7])
    else $error("enable change not recorded");

    chk_device_flags:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        i_ev.thermal_shutdown_trip || i_ev.supply_lockout || i_ev.pass_transistor_bad
        || i_ev.instant_overpower_trip || i_ev.timed_overpower_trip |=>
        (status_reg[6] & 8'h7C) != 8'h00)
    else $error("device specific event not latched");

    chk_w1c_clears:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req.wr && acc_kind == fsab_pkg::FSAB_ACC_STATUS && acc_idx == 3'h0 &&
         i_req.wdata[6] && !i_ev.out_overvolt_warn) |=> !status_reg[0][6])
    else $error("write one did not clear status bit");

    chk_force_sets:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_req.wr && acc_kind == fsab_pkg::FSAB_ACC_FORCE) |=>
        ((status_reg[$past(acc_idx)] & $past(i_req.wdata))
         == ($past(i_req.wdata) & fsab_pkg::FSAB_IMPL[$past(acc_idx)])))
    else $error("force write did not set status bits");

    chk_alert_follow:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        1'b1 |=> (o_alert_oe == $past(alert_next)) && !o_alert_out)
    else $error("alert pin does not follow unmasked status");

    chk_reserved_zero:
    assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !reserved_seen)
    else $error("reserved bit holds state");

endmodule

// [fsab_bank_tb.sv]
/* Self-checking bench for the fault status bank.
   Assumes the host model on the command port; pins and events change at falling edges. */
`timescale 1ns/10ps
module fsab_bank_tb;
    // ----
    // harness
    // ----
    logic                     i_ref_clk = 1'b0;
    logic                     i_sys_rst = 1'b1;
    fsab_pkg::fsab_req_type   req;
    fsab_pkg::fsab_event_type ev = '0;
    logic                     tmr = 1'b0;
    logic                     ovp = 1'b0;
    logic                     uvp = 1'b0;
    logic                     enp = 1'b0;
    logic [7:0]               rd_data;
    logic                     rd_valid;
    logic                     alert_out;
    logic                     alert_oe;
    logic                     alert_wire;
    int                       n_mismatch = 0;
    int                       compares = 0;
    // bit position of each event -> {status cmd, expected byte}; 0 = needs timer pin
    localparam logic [15:0] EV_MAP [19] = '{16'h8004, 16'h8008, 16'h8010, 16'h8020,
        16'h8040, 16'h7E02, 16'h7E20, 16'h7E40, 16'h7E80, 16'h7D20, 16'h7D40, 16'h7D80,
        16'h7C01, 16'h7C20, 16'h7C40, 16'h7B20, 16'h0000, 16'h7A20, 16'h7A40};
    localparam logic [7:0] GATE_DEF [7] = '{8'h60, 8'hA0, 8'hF1, 8'hE0, 8'hE2, 8'h00, 8'hFC};
    always #20 i_ref_clk = ~i_ref_clk;
    // pulled-up shared wire, this device the only one pulling
    assign alert_wire = alert_oe ? alert_out : 1'b1;
    fsab_bank fsab_bank_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(req),
        .i_ev(ev), .i_fault_timer_pin(tmr), .i_overvolt_pin(ovp), .i_undervolt_pin(uvp),
        .i_enable_pin(enp), .i_alert_in(alert_wire), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_alert_out(alert_out), .o_alert_oe(alert_oe));
    fsab_host_model fsab_host_model_inst (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_req(req));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic expect_byte(input logic [15:0] cmd, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        fsab_host_model_inst.read_reg(cmd, d, ok);
        compares++;
        if ((ok ? d : 8'hXX) !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t cmd %h got %h exp %h", $time, cmd, d, exp);
        end
    endtask
    task automatic wait_alert(input logic exp);
        int k;
        for (k = 0; k < 8 && alert_oe !== exp; k++)
            @(negedge i_ref_clk);
        compares++;
        if (alert_oe !== exp || alert_out !== 1'b0) begin
            n_mismatch++;
            $display("FAIL t=%0t alert drive not %b", $time, exp);
            tally_and_finish();
        end
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        int i;
        for (i = 0; i < 7; i++) begin
            expect_byte(16'h007A + 16'(i), 8'h00);
            if (i != 5)
                expect_byte(16'hFED2 + 16'(i), GATE_DEF[i]);
        end
        $display("test reset done");
    endtask
    task automatic t_events();
        int i;
        for (i = 0; i < 19; i++) begin
            if (EV_MAP[i] == 16'h0000)
                continue;
            @(negedge i_ref_clk);
            ev = fsab_pkg::fsab_event_type'(19'h00001 << i);
            @(negedge i_ref_clk);
            ev = '0;
            expect_byte({8'h00, EV_MAP[i][15:8]}, EV_MAP[i][7:0]);
            fsab_host_model_inst.write_reg({8'h00, EV_MAP[i][15:8]}, 8'hFF);
            expect_byte({8'h00, EV_MAP[i][15:8]}, 8'h00);
        end
        $display("test events done");
    endtask
    task automatic pulse_pin(ref logic pin, input logic [15:0] cmd, input logic [7:0] exp);
        repeat (2) @(negedge i_ref_clk);
        pin = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        pin = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        expect_byte(cmd, exp);
        fsab_host_model_inst.write_reg(cmd, 8'hFF);
    endtask
    task automatic t_pins();
        pulse_pin(ovp, 16'h007C, 8'h80);
        pulse_pin(uvp, 16'h007C, 8'h10);
        pulse_pin(enp, 16'h0080, 8'h80);
        pulse_pin(tmr, 16'h007B, 8'h00);
        ev.overcurrent_active = 1'b1;
        pulse_pin(tmr, 16'h007B, 8'h80);
        ev = '0;
        $display("test pins done");
    endtask
    task automatic t_force_gate();
        fsab_host_model_inst.write_reg(16'hFEC2, 8'hFF);
        expect_byte(16'hFEC2, 8'h60);
        fsab_host_model_inst.write_reg(16'h007A, 8'h40);
        expect_byte(16'h007A, 8'h20);
        wait_alert(1'b0);
        fsab_host_model_inst.write_reg(16'hFED2, 8'h40);
        wait_alert(1'b1);
        expect_byte(16'h007F, 8'h01);
        fsab_host_model_inst.write_reg(16'hFED2, 8'hFF);
        expect_byte(16'hFED2, 8'h60);
        wait_alert(1'b0);
        fsab_host_model_inst.write_reg(16'h007F, 8'h01);
        expect_byte(16'h007F, 8'h00);
        // unmapped place reads zero and flags a bad command
        expect_byte(16'hFEC7, 8'h00);
        expect_byte(16'h007E, 8'h80);
        $display("test force and gate done");
    endtask
    task automatic t_reset_mid();
        fsab_host_model_inst.write_reg(16'hFEC5, 8'h40);
        fsab_host_model_inst.write_reg(16'hFED5, 8'h00);
        wait_alert(1'b1);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        wait_alert(1'b0);
        expect_byte(16'h007D, 8'h00);
        expect_byte(16'hFED5, 8'hE0);
        $display("test mid reset done");
    endtask
    initial begin
        repeat (12) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        t_reset();
        t_events();
        t_pins();
        t_force_gate();
        t_reset_mid();
        tally_and_finish();
    end
endmodule

// [fsab_host_model.sv]
/* Host model: issues command-code reads and writes on the bank's port.
   Assumes the caller shares the bank's clock; requests change at falling edges. */
`timescale 1ns/10ps
module fsab_host_model (
    input  wire logic                  i_ref_clk,
    input  wire logic [7:0]            i_rd_data,
    input  wire logic                  i_rd_valid,
    output fsab_pkg::fsab_req_type     o_req
);
    // ----
    // port cycles
    // ----
    initial o_req = '0;
    // one rising edge per request: the port takes pulses, not levels
    task automatic write_reg(input logic [15:0] cmd, input logic [7:0] data);
        @(negedge i_ref_clk);
        o_req = '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: data};
        @(negedge i_ref_clk);
        o_req = '0;
    endtask
    task automatic read_reg(input logic [15:0] cmd, output logic [7:0] data, output logic ok);
        @(negedge i_ref_clk);
        o_req = '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 8'h00};
        @(negedge i_ref_clk);
        o_req = '0;
        ok = (i_rd_valid === 1'b1);
        data = i_rd_data;
    endtask
endmodule

// [fsab_pkg.sv]
/*
 * Constants, carriers and offsets for the fault status and alert bank.
 * Assumes a command-code register port from a serial-port engine on the
 * same clock, and event levels from converter logic on the same clock.
 */
package fsab_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int FSAB_NREG      = 7;
    localparam int FSAB_OTHER_IDX = 5;

    localparam logic [15:0] FSAB_STATUS_OFS [FSAB_NREG] = '{
        16'h007A, 16'h007B, 16'h007C, 16'h007D, 16'h007E, 16'h007F, 16'h0080};
    localparam logic [15:0] FSAB_FORCE_OFS [FSAB_NREG] = '{
        16'hFEC2, 16'hFEC3, 16'hFEC4, 16'hFEC5, 16'hFEC6, 16'hFED7, 16'hFEC8};
    // misc register has no gate; its slot is never matched
    localparam logic [15:0] FSAB_GATE_OFS [FSAB_NREG] = '{
        16'hFED2, 16'hFED3, 16'hFED4, 16'hFED5, 16'hFED6, 16'h0000, 16'hFED8};
    localparam logic [FSAB_NREG-1:0] FSAB_GATE_PRESENT = 7'h5F;

    localparam logic [7:0] FSAB_IMPL [FSAB_NREG] = '{
        8'h60, 8'hA0, 8'hF1, 8'hE0, 8'hE2, 8'h01, 8'hFC};
    localparam logic [7:0] FSAB_GATE_RST [FSAB_NREG] = '{
        8'h60, 8'hA0, 8'hF1, 8'hE0, 8'hE2, 8'h00, 8'hFC};
    localparam logic [7:0] FSAB_STATUS_RST = 8'h00;
    localparam logic [7:0] FSAB_RDATA_RST  = 8'h00;

    // register indices
    localparam int FSAB_VOUT_IDX  = 0;
    localparam int FSAB_IOUT_IDX  = 1;
    localparam int FSAB_INPUT_IDX = 2;
    localparam int FSAB_TEMP_IDX  = 3;
    localparam int FSAB_CML_IDX   = 4;
    localparam int FSAB_MFR_IDX   = 6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FSAB_OUT_OVW_BIT    = 6;
    localparam int FSAB_OUT_UVW_BIT    = 5;
    localparam int FSAB_OC_TRIP_BIT    = 7;
    localparam int FSAB_OC_WARN_BIT    = 5;
    localparam int FSAB_IN_OVT_BIT     = 7;
    localparam int FSAB_IN_OVW_BIT     = 6;
    localparam int FSAB_IN_UVW_BIT     = 5;
    localparam int FSAB_IN_UVT_BIT     = 4;
    localparam int FSAB_PWR_WARN_BIT   = 0;
    localparam int FSAB_OT_TRIP_BIT    = 7;
    localparam int FSAB_OT_WARN_BIT    = 6;
    localparam int FSAB_UT_WARN_BIT    = 5;
    localparam int FSAB_BAD_CMD_BIT    = 7;
    localparam int FSAB_BAD_DATA_BIT   = 6;
    localparam int FSAB_PKT_ERR_BIT    = 5;
    localparam int FSAB_MISC_COMM_BIT  = 1;
    localparam int FSAB_FIRST_BIT      = 0;
    localparam int FSAB_EN_CHG_BIT     = 7;
    localparam int FSAB_TSD_BIT        = 6;
    localparam int FSAB_LOCKOUT_BIT    = 5;
    localparam int FSAB_INST_OP_BIT    = 4;
    localparam int FSAB_TIMED_OP_BIT   = 3;
    localparam int FSAB_FET_BAD_BIT    = 2;

    // synchronised pin positions
    localparam int FSAB_PIN_TIMER = 0;
    localparam int FSAB_PIN_OV    = 1;
    localparam int FSAB_PIN_UV    = 2;
    localparam int FSAB_PIN_EN    = 3;
    localparam int FSAB_PIN_ALERT = 4;
    localparam int FSAB_NPIN      = 5;
    localparam logic [FSAB_NPIN-1:0] FSAB_SYNC_RST = 5'h10;

    // cycles after reset before the enable pin sample is trusted
    localparam logic [1:0] FSAB_SETTLE_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSAB_ACC_NONE   = 2'b00,
        FSAB_ACC_STATUS = 2'b01,
        FSAB_ACC_FORCE  = 2'b11,
        FSAB_ACC_GATE   = 2'b10
    } fsab_acc_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] cmd;
        logic [7:0]  wdata;
    } fsab_req_type;

    typedef struct packed {
        logic out_overvolt_warn;
        logic out_undervolt_warn;
        logic overcurrent_active;
        logic overcurrent_warn;
        logic in_overvolt_warn;
        logic in_undervolt_warn;
        logic input_power_warn;
        logic overheat_trip;
        logic overheat_warn;
        logic undercool_warn;
        logic bad_cmd;
        logic bad_data;
        logic packet_check_error;
        logic misc_comm_fault;
        logic thermal_shutdown_trip;
        logic supply_lockout;
        logic instant_overpower_trip;
        logic timed_overpower_trip;
        logic pass_transistor_bad;
    } fsab_event_type;

endpackage
